/* core/lcd_drive_pkg.sv */
// Purpose: Shared constants and types for the column output drive control.
// Assumes: APB data 32 bits, byte addresses on aligned words.
// Notes:   Panel clock, strobe and output enable are pins, not clocks.
package lcd_drive_pkg;

	// Register byte addresses
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_INDEX  = 12'h008;
	localparam logic [11:0] ADDR_DATA   = 12'h00c;

	// Control register fields
	localparam int CTRL_DRIVE_BIT  = 0;
	localparam int CTRL_COLOUR_BIT = 1;
	localparam int CTRL_POL_BIT    = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Status register fields
	localparam int STAT_DRIVE_LSB = 0;
	localparam int STAT_COUNT_LSB = 4;
	localparam int STAT_OE_BIT    = 8;

	// Column data width and decode length in panel clock edges
	localparam int LEVEL_W = 6;
	localparam logic [2:0] DECODE_EDGES = 3'h4;

	// Output stage drive condition
	typedef enum logic [1:0] {
		DRV_HIZ,
		DRV_AMP,
		DRV_SWITCH,
		DRV_GROUND
	} drive_state_t;

	// Line sequencer
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_DECODE,
		SEQ_WAIT_OE,
		SEQ_AMP,
		SEQ_SWITCH,
		SEQ_GROUND
	} seq_t;

endpackage

/* core/lcd_column_cell.sv */
// Purpose: One column: data register, output latch and decoded level.
// Assumes: All strobes are one-cycle pulses on pclk.
// Notes:   Level changes only on the decode pulse.
`timescale 1ns/1ps
module lcd_column_cell #(
	parameter int LEVEL_W = 6
)(
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Data load
	input  wire logic               write_enable,
	input  wire logic [LEVEL_W-1:0] write_data,
	// Line control
	input  wire logic               latch_pulse,
	input  wire logic               decode_pulse,
	input  wire logic               colour_mode_select,
	// Decoded level
	output logic      [LEVEL_W-1:0] level
);
	typedef struct packed {
		logic [LEVEL_W-1:0] data_reg;
		logic [LEVEL_W-1:0] out_latch;
		logic [LEVEL_W-1:0] level;
	} cell_t;

	cell_t c;
	cell_t next_c;

	// Load, latch and decode
	always_comb begin
		next_c = c;
		if (write_enable) begin
			next_c.data_reg = write_data;
		end
		if (latch_pulse) begin
			next_c.out_latch = c.data_reg;
		end
		if (decode_pulse) begin
			// Eight-colour uses the MSB only, full rail white or black
			next_c.level = colour_mode_select ?
				{LEVEL_W{c.out_latch[LEVEL_W-1]}} : c.out_latch;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	assign level = c.level;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	eight_colour_a: assert property (
		decode_pulse && colour_mode_select |=>
			level == {LEVEL_W{$past(c.out_latch[LEVEL_W-1])}})
		else $error("eight colour level not full rail");

	full_colour_a: assert property (
		decode_pulse && !colour_mode_select |=>
			level == $past(c.out_latch))
		else $error("full colour level not copied");

endmodule // lcd_column_cell

/* core/lcd_source_output_drive_control.sv */
// Purpose: Output stage control of an LCD column driver, APB controlled.
// Assumes: Panel clock well below pclk/2; pins are asynchronous.
// Notes:   Pin events are seen two pclk edges late through synchronisers.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps

// Summary of operation
// - Drive mode low: output enable steers outputs
// - Decode latched data over panel edges one-four
// - Outputs high impedance from strobe to fourth edge
// - Enable low after decode: wait, amplify on rise
// - Enable held high: amplify after fourth edge
// - Enable falling in amplify: go switch hold
// - Switch hold stops amplifier bias current
// - Drive mode high: enable fall grounds outputs
// - Ground mode: strobe samples enable to resume
// - Latch pulse copies data register to latch
// - Colour mode high: MSB picks white/black
// - Strobe rise ends amplify, back to high impedance
module lcd_source_output_drive_control #(
	parameter int NUM_COLUMNS = 240
)(
	// APB slave
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [11:0]               paddr,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	// Panel timing pins
	input  wire logic                      panel_clock,
	input  wire logic                      line_strobe,
	input  wire logic                      output_enable,
	// Output stage
	output lcd_drive_pkg::drive_state_t    drive_state,
	output logic                           amp_bias_enable,
	output logic                           gamma_negative,
	output logic [NUM_COLUMNS*lcd_drive_pkg::LEVEL_W-1:0] column_level
);
	import lcd_drive_pkg::*;

	localparam int AW = (NUM_COLUMNS > 1) ? $clog2(NUM_COLUMNS) : 1;
	localparam logic [AW-1:0] LAST_COL = AW'(NUM_COLUMNS - 1);

	typedef struct packed {
		logic [2:0]   strobe_sync;
		logic [2:0]   oe_sync;
		logic [2:0]   clk_sync;
		seq_t         seq;
		logic [2:0]   edge_count;
		logic         oe_at_strobe;
		logic         drive_mode;
		logic         colour_mode_select;
		logic         polarity_select;
		logic [AW-1:0] write_index;
		logic         latch_pulse;
		logic         decode_pulse;
		drive_state_t drive_state;
		logic         amp_bias_enable;
		logic         gamma_negative;
		logic         pready;
		logic         pslverr;
		logic [31:0]  prdata;
	} state_t;

	state_t s;
	state_t next_s;

	logic strobe_rise;
	logic clk_rise;
	logic oe_rise;
	logic oe_fall;
	logic oe_lvl;
	logic apb_access;
	logic apb_commit;
	logic data_write;
	logic addr_known;
	logic [31:0] read_word;

	// Edges from the second and third synchroniser stages only
	assign strobe_rise = s.strobe_sync[1] & ~s.strobe_sync[2];
	assign clk_rise    = s.clk_sync[1] & ~s.clk_sync[2];
	assign oe_rise     = s.oe_sync[1] & ~s.oe_sync[2];
	assign oe_fall     = ~s.oe_sync[1] & s.oe_sync[2];
	assign oe_lvl      = s.oe_sync[1];

	// APB phases; a write lands only on the edge that sees pready high
	assign apb_access = psel & penable;
	assign apb_commit = apb_access & s.pready;
	assign data_write = apb_commit & pwrite & (paddr == ADDR_DATA);

	// Address decode and read mux
	always_comb begin
		addr_known = 1'b1;
		read_word  = 32'h0;
		unique case (paddr)
			ADDR_CTRL: begin
				read_word[CTRL_DRIVE_BIT]  = s.drive_mode;
				read_word[CTRL_COLOUR_BIT] = s.colour_mode_select;
				read_word[CTRL_POL_BIT]    = s.polarity_select;
			end
			ADDR_STATUS: begin
				read_word[STAT_DRIVE_LSB +: 2] = s.drive_state;
				read_word[STAT_COUNT_LSB +: 3] = s.edge_count;
				read_word[STAT_OE_BIT]         = s.oe_at_strobe;
			end
			ADDR_INDEX: begin
				read_word[AW-1:0] = s.write_index;
			end
			ADDR_DATA: begin
				read_word = 32'h0; // Write only
			end
			default: begin
				addr_known = 1'b0;
			end
		endcase
	end

	// Maps a sequencer state onto the output stage condition
	function automatic drive_state_t drive_of(input seq_t q);
		drive_state_t d;
		d = DRV_HIZ;
		unique case (q)
			SEQ_AMP:    d = DRV_AMP;
			SEQ_SWITCH: d = DRV_SWITCH;
			SEQ_GROUND: d = DRV_GROUND;
			SEQ_IDLE, SEQ_DECODE, SEQ_WAIT_OE: d = DRV_HIZ;
		endcase
		return d;
	endfunction

	// Next state: synchronisers, APB, line sequencer
	always_comb begin
		next_s = s;
		next_s.strobe_sync  = {s.strobe_sync[1:0], line_strobe};
		next_s.oe_sync      = {s.oe_sync[1:0], output_enable};
		next_s.clk_sync     = {s.clk_sync[1:0], panel_clock};
		next_s.latch_pulse  = 1'b0;
		next_s.decode_pulse = 1'b0;

		// One wait state keeps prdata and pslverr registered
		next_s.pready = apb_access & ~s.pready;
		if (apb_access & ~s.pready) begin
			next_s.prdata  = pwrite ? 32'h0 : read_word;
			next_s.pslverr = ~addr_known;
		end
		if (apb_commit & pwrite) begin
			if (paddr == ADDR_CTRL) begin
				next_s.drive_mode         = pwdata[CTRL_DRIVE_BIT];
				next_s.colour_mode_select = pwdata[CTRL_COLOUR_BIT];
				next_s.polarity_select    = pwdata[CTRL_POL_BIT];
			end
			if (paddr == ADDR_INDEX) begin
				next_s.write_index = pwdata[AW-1:0];
			end
		end
		// Auto-increment lets software stream a whole line
		if (data_write) begin
			next_s.write_index = (s.write_index == LAST_COL) ?
				'0 : s.write_index + 1'b1;
		end

		// Line sequencer
		if (strobe_rise) begin
			next_s.latch_pulse  = 1'b1;
			next_s.oe_at_strobe = oe_lvl;
			next_s.edge_count   = 3'h0;
			// Ground holds unless enable was high at the strobe
			if (!(s.seq == SEQ_GROUND && !oe_lvl)) begin
				next_s.seq = SEQ_DECODE;
			end
		end else begin
			unique case (s.seq)
				SEQ_IDLE: begin
					next_s.seq = SEQ_IDLE;
				end
				SEQ_DECODE: begin
					if (s.drive_mode && oe_fall) begin
						next_s.seq = SEQ_GROUND;
					end else if (clk_rise) begin
						next_s.edge_count = s.edge_count + 3'h1;
						if (s.edge_count == DECODE_EDGES - 3'h1) begin
							next_s.decode_pulse = 1'b1;
							// Ground mode resumes normal amplify
							if (s.drive_mode || oe_lvl) begin
								next_s.seq = SEQ_AMP;
							end else begin
								next_s.seq = SEQ_WAIT_OE;
							end
						end
					end
				end
				SEQ_WAIT_OE: begin
					if (oe_rise || s.drive_mode) begin
						next_s.seq = SEQ_AMP;
					end
				end
				SEQ_AMP: begin
					if (oe_fall) begin
						next_s.seq = s.drive_mode ?
							SEQ_GROUND : SEQ_SWITCH;
					end
				end
				SEQ_SWITCH: begin
					next_s.seq = SEQ_SWITCH; // Holds until strobe
				end
				SEQ_GROUND: begin
					next_s.seq = SEQ_GROUND;
				end
				default: begin
					next_s.seq = SEQ_IDLE;
				end
			endcase
		end

		// Registered drive and bias outputs follow the next sequencer state; gamma_negative follows polarity
		next_s.drive_state     = drive_of(next_s.seq);
		next_s.amp_bias_enable = (next_s.seq == SEQ_AMP);
		next_s.gamma_negative  = s.polarity_select;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.drive_mode         <= CTRL_RESET[CTRL_DRIVE_BIT];
			s.colour_mode_select <= CTRL_RESET[CTRL_COLOUR_BIT];
			s.polarity_select    <= CTRL_RESET[CTRL_POL_BIT];
		end else begin
			s <= next_s;
		end
	end

	// Column cells; level does not depend on polarity
	generate
		for (genvar i = 0; i < NUM_COLUMNS; i++) begin : g_col
			lcd_column_cell #(
				.LEVEL_W (LEVEL_W)
			) u_cell (
				.pclk               (pclk),
				.presetn            (presetn),
				.write_enable       (data_write &&
				                     (s.write_index == AW'(i))),
				.write_data         (pwdata[LEVEL_W-1:0]),
				.latch_pulse        (s.latch_pulse),
				.decode_pulse       (s.decode_pulse),
				.colour_mode_select (s.colour_mode_select),
				.level              (column_level[i*LEVEL_W +: LEVEL_W])
			);
		end
	endgenerate

	// Outputs
	assign prdata          = s.prdata;
	assign pready          = s.pready;
	assign pslverr         = s.pslverr;
	assign drive_state     = s.drive_state;
	assign amp_bias_enable = s.amp_bias_enable;
	assign gamma_negative  = s.gamma_negative;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	strobe_to_hiz_a: assert property (
		strobe_rise && !(s.seq == SEQ_GROUND && !oe_lvl) |=>
			drive_state == DRV_HIZ)
		else $error("strobe did not force high impedance");

	latch_on_strobe_a: assert property (
		strobe_rise |=> s.latch_pulse ##1 !s.latch_pulse)
		else $error("latch pulse missing after strobe");

	decode_fourth_a: assert property (
		s.seq == SEQ_DECODE && clk_rise && !strobe_rise &&
		s.edge_count == 3'h3 && !(s.drive_mode && oe_fall) |=>
			s.decode_pulse && s.edge_count == DECODE_EDGES)
		else $error("decode not on fourth panel edge");

	hiz_in_decode_a: assert property (
		s.seq == SEQ_DECODE |-> drive_state == DRV_HIZ &&
			s.edge_count < DECODE_EDGES)
		else $error("outputs driven before decode done");

	// Enable must already have been high on the decode decision edge
	auto_amp_a: assert property (
		s.decode_pulse && oe_lvl && !oe_rise && !strobe_rise &&
		!oe_fall |-> drive_state == DRV_AMP)
		else $error("no amplify after decode with enable high");

	wait_enable_a: assert property (
		s.seq == SEQ_WAIT_OE && !s.drive_mode && !strobe_rise |=>
			(drive_state == DRV_AMP) == $past(oe_rise))
		else $error("wait for enable rise broken");

	amp_to_switch_a: assert property (
		s.seq == SEQ_AMP && oe_fall && !s.drive_mode &&
		!strobe_rise |=> drive_state == DRV_SWITCH ##1
			(drive_state == DRV_SWITCH || $past(strobe_rise)))
		else $error("enable fall did not select switch hold");

	bias_off_a: assert property (
		amp_bias_enable == (drive_state == DRV_AMP))
		else $error("bias current on outside amplify");

	ground_fall_a: assert property (
		s.seq == SEQ_AMP && oe_fall && s.drive_mode &&
		!strobe_rise |=> drive_state == DRV_GROUND)
		else $error("enable fall did not ground outputs");

	ground_resume_a: assert property (
		s.seq == SEQ_GROUND && strobe_rise |=>
			(s.seq == SEQ_DECODE) == $past(oe_lvl))
		else $error("ground resume not set by strobe sample");

	polarity_level_a: assert property (
		$changed(s.polarity_select) && !s.decode_pulse |=>
			$stable(column_level))
		else $error("polarity changed the column level");

	// One wait state: the second access cycle answers, once only
	apb_answer_a: assert property (
		apb_access && !pready |=> pready)
		else $error("access cycle not answered next cycle");

	apb_single_a: assert property (
		pready |=> !pready)
		else $error("ready held for more than one cycle");

	auto_amp_c: cover property (
		s.seq == SEQ_DECODE ##1 s.seq == SEQ_AMP);
	switch_hold_c: cover property (
		s.seq == SEQ_AMP ##1 s.seq == SEQ_SWITCH);
	wait_enable_c: cover property (
		s.seq == SEQ_WAIT_OE ##1 s.seq == SEQ_AMP);
	ground_resume_c: cover property (
		s.seq == SEQ_GROUND ##1 s.seq == SEQ_DECODE);
	ground_hold_c: cover property (
		s.seq == SEQ_GROUND && strobe_rise && !oe_lvl);

endmodule // lcd_source_output_drive_control

/* testbench/panel_model.sv */
// Purpose: Panel timing controller model: strobe, panel clock, enable.
// Assumes: Pins change just after a pclk rise, by non-blocking assignment.
// Notes:   Panel clock stands still low between lines.
`timescale 1ns/1ps
module panel_model (
	// Clock
	input  wire logic pclk,
	// Panel pins
	output logic      panel_clock,
	output logic      line_strobe,
	output logic      output_enable
);
	// Pclk edges per panel clock phase; two is the shortest counted
	int half = 2;

	// Pins idle low from time zero
	initial begin
		panel_clock = 1'b0;
		line_strobe = 1'b0;
		output_enable = 1'b0;
	end

	// One strobe pulse, high for one panel clock phase
	task strobe();
		@(posedge pclk) line_strobe <= 1'b1;
		repeat (half) @(posedge pclk);
		line_strobe <= 1'b0;
	endtask

	// Burst of panel clocks; slow phases stretch each half
	task clocks(input int n);
		repeat (n) begin
			repeat (half) @(posedge pclk);
			panel_clock <= 1'b1;
			repeat (half) @(posedge pclk);
			panel_clock <= 1'b0;
		end
	endtask

	// Enable level change
	task set_oe(input logic v);
		@(posedge pclk) output_enable <= v;
	endtask
endmodule // panel_model

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the column output drive control.
// Assumes: Four columns keep the line loads short.
// Notes:   State changes are checked in order against a queue of notes.
`timescale 1ns/1ps
module tb_top;
	import lcd_drive_pkg::*;
	localparam int NC = 4;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [11:0]           paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  panel_clock;
	logic                  line_strobe;
	logic                  output_enable;
	drive_state_t          drive_state;
	drive_state_t          prev_st = DRV_HIZ;
	logic                  amp_bias_enable;
	logic                  gamma_negative;
	logic [NC*LEVEL_W-1:0] column_level;
	logic [32:0]           exp_rd[$];
	drive_state_t          exp_st[$];
	logic [5:0]            vals[NC];
	int                    seed = 87299;
	int                    miscompares = 0;
	int                    n_tests = 0;

	// 50 MHz clock
	always #10 pclk = ~pclk;

	lcd_source_output_drive_control #(.NUM_COLUMNS(NC)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .panel_clock(panel_clock),
		.line_strobe(line_strobe), .output_enable(output_enable),
		.drive_state(drive_state), .amp_bias_enable(amp_bias_enable),
		.gamma_negative(gamma_negative), .column_level(column_level));

	panel_model partner (.pclk(pclk), .panel_clock(panel_clock),
		.line_strobe(line_strobe), .output_enable(output_enable));

	// Comparisons
	task cmp_word(input logic [32:0] g, input logic [32:0] e);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task cmp_state(input drive_state_t g, input drive_state_t e);
		cmp_word({31'h0, g}, {31'h0, e});
	endtask
	task cmp_bit(input logic g, input logic e);
		cmp_word({32'h0, g}, {32'h0, e});
	endtask

	// Verdict and end of run
	task complete_run();
		$display("miscompares %0d n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task timeout();
		miscompares++;
		complete_run();
	endtask

	// Monitor: read answers, state changes, bias follows amplify
	always @(posedge pclk) begin
		if (presetn && psel && penable && pready && !pwrite)
			if (exp_rd.size() > 0)
				cmp_word({pslverr, prdata}, exp_rd.pop_front());
		if (presetn && drive_state !== prev_st) begin
			if (exp_st.size() > 0)
				cmp_state(drive_state, exp_st.pop_front());
			else
				cmp_state(drive_state, prev_st);
		end
		if (presetn)
			cmp_bit(amp_bias_enable, drive_state == DRV_AMP);
		prev_st = drive_state;
	end

	// APB transfer; held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			exp_rd.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
			timeout();
	endtask

	// Wait until every noted state change has been seen
	task settle();
		int i;
		for (i = 0; i < 80; i++) begin
			@(posedge pclk);
			if (exp_st.size() == 0)
				break;
		end
		if (i == 80)
			timeout();
		repeat (3) @(posedge pclk);
	endtask

	// One line at a random panel speed, four clocks after the strobe
	task frame();
		partner.half = 2 + {$random(seed)} % 4;
		partner.strobe();
		partner.clocks(4);
	endtask

	// Column levels; 8-colour mode spreads the MSB over the level
	task check_lv(input logic mono);
		for (int c = 0; c < NC; c++)
			cmp_word({27'h0, column_level[c*LEVEL_W +: LEVEL_W]},
				{27'h0, mono ? {6{vals[c][5]}} : vals[c]});
	endtask

	// Main sequence
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0, {30'h0, CTRL_RESET});
		apb(1'b1, ADDR_INDEX, 32'h0, 33'h0);
		for (int c = 0; c < NC; c++) begin
			vals[c] = 6'($random(seed));
			apb(1'b1, ADDR_DATA, {26'h0, vals[c]}, 33'h0);
		end
		apb(1'b0, ADDR_INDEX, 32'h0, 33'h0);
		apb(1'b0, ADDR_DATA, 32'h0, 33'h0);
		apb(1'b1, 12'h010, 32'h7, 33'h0);
		apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
		apb(1'b0, ADDR_CTRL, 32'h0, 33'h0);
		// Enable held high: amplify only after the fourth clock
		partner.set_oe(1'b1);
		partner.strobe();
		partner.clocks(3);
		repeat (8) @(posedge pclk);
		cmp_state(drive_state, DRV_HIZ);
		exp_st.push_back(DRV_AMP);
		partner.clocks(1);
		settle();
		check_lv(1'b0);
		// Status: amplify, four edges counted, enable high at strobe
		apb(1'b0, ADDR_STATUS, 32'h0, 33'h0_0000_0141);
		cmp_bit(gamma_negative, 1'b0);
		// Enable stays high a while so levels settle before the hold
		repeat (8) @(posedge pclk);
		exp_st.push_back(DRV_SWITCH);
		partner.set_oe(1'b0);
		settle();
		// 8-colour, negative curve, enable low after decode
		apb(1'b1, ADDR_CTRL, 32'h6, 33'h0);
		exp_st.push_back(DRV_HIZ);
		frame();
		settle();
		repeat (8) @(posedge pclk);
		cmp_state(drive_state, DRV_HIZ);
		exp_st.push_back(DRV_AMP);
		partner.set_oe(1'b1);
		settle();
		check_lv(1'b1);
		cmp_bit(gamma_negative, 1'b1);
		// Strobe out of amplify with the polarity turned back
		apb(1'b1, ADDR_CTRL, 32'h2, 33'h0);
		exp_st.push_back(DRV_HIZ);
		exp_st.push_back(DRV_AMP);
		frame();
		settle();
		check_lv(1'b1);
		cmp_bit(gamma_negative, 1'b0);
		// Ground output: a strobe with enable low keeps ground
		apb(1'b1, ADDR_CTRL, 32'h3, 33'h0);
		exp_st.push_back(DRV_GROUND);
		partner.set_oe(1'b0);
		settle();
		frame();
		repeat (8) @(posedge pclk);
		partner.set_oe(1'b1);
		repeat (8) @(posedge pclk);
		cmp_state(drive_state, DRV_GROUND);
		exp_st.push_back(DRV_HIZ);
		exp_st.push_back(DRV_AMP);
		frame();
		settle();
		// Second reset in mid-run
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		cmp_state(drive_state, DRV_HIZ);
		cmp_word({9'h0, column_level}, 33'h0);
		presetn <= 1'b1;
		apb(1'b0, ADDR_CTRL, 32'h0, 33'h0);
		// Let the monitor take the last answer before the verdict
		repeat (2) @(posedge pclk);
		cmp_word(33'(exp_rd.size() + exp_st.size()), 33'h0);
		complete_run();
	end
endmodule // tb_top
